// ==== src/frt_pkg.sv ====
// constants and types of the timer interrupt and capture filter block
// Functional notes
// [RL1] request only while flag and enable set
// [RL2] one request line per interrupt type
// [RL3] priority capture, match a, match b, wrap
// [RL4] four series latches sample on sample clock
// [RL5] output follows latches only when all agree
// [RL6] filter output is low after reset
// [RL7] select 00 off, 01 /32, 10 /64, 11 /128
// [RL8] clear beats counter low byte write
// [RL9] counter low byte write beats increment
// [RL10] compare low byte write inhibits its match
// [RL11] increment on falling edge of source
// [RL12] high to low source switch counts once
// [RL13] internal/external switch may count once
// [RL14] filtered capture 3-4 samples, +1 if read
// [RL15] capture sets flag and copies counter together
// [RL16] wrap flag on all ones to zero
// [RL17] request is a level, drops next cycle
package frt_pkg;
  localparam logic [4:0] OFS_CONTROL  = 5'h00;
  localparam logic [4:0] OFS_STATUS   = 5'h04;
  localparam logic [4:0] OFS_IRQ_EN   = 5'h08;
  localparam logic [4:0] OFS_COUNTER  = 5'h0C;
  localparam logic [4:0] OFS_CMP_A    = 5'h10;
  localparam logic [4:0] OFS_CMP_B    = 5'h14;
  localparam logic [4:0] OFS_CAPTURED = 5'h18;
  localparam logic [4:0] OFS_FILTER   = 5'h1C;
  localparam int CTL_CLK_LO = 0;
  localparam int CTL_CLK_HI = 1;
  localparam int CTL_EDGE   = 2;
  localparam int CTL_CLRA   = 3;
  localparam int FLT_SMP_LO = 0;
  localparam int FLT_SMP_HI = 1;
  localparam logic [3:0]  CTRL_RST    = 4'h0;
  localparam logic [7:0]  FILTER_RST  = 8'hFC;
  localparam logic [15:0] COUNTER_RST = 16'h0000;
  localparam logic [15:0] COMPARE_RST = 16'hFFFF;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [1:0] CLK_DIV2 = 2'h0;
  localparam logic [1:0] CLK_DIV8 = 2'h1;
  localparam logic [1:0] CLK_DIV32 = 2'h2;
  localparam logic [1:0] CLK_EXT  = 2'h3;
  localparam int TAP_DIV2  = 0;
  localparam int TAP_DIV8  = 2;
  localparam int TAP_DIV32 = 4;
  localparam logic [1:0] SMP_OFF = 2'h0;
  localparam logic [1:0] SMP_32  = 2'h1;
  localparam logic [1:0] SMP_64  = 2'h2;
  localparam logic [1:0] SMP_128 = 2'h3;
  localparam logic [6:0] MASK_32  = 7'h1F;
  localparam logic [6:0] MASK_64  = 7'h3F;
  localparam logic [6:0] MASK_128 = 7'h7F;
  localparam logic [1:0] CODE_CAP  = 2'h0;
  localparam logic [1:0] CODE_MA   = 2'h1;
  localparam logic [1:0] CODE_MB   = 2'h2;
  localparam logic [1:0] CODE_WRAP = 2'h3;
  typedef struct packed {
    logic wrap;
    logic match_b;
    logic match_a;
    logic capture;
  } frt_flags_type;
endpackage : frt_pkg

// ==== src/frt_timer_irq_filter.sv ====
// timer channel: interrupt requests, capture filter, counter contention
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module frt_timer_irq_filter
  import frt_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  input  wire logic        i_capture_pin,
  input  wire logic        i_ext_clk,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_capture_irq,
  output logic             o_compare_a_irq,
  output logic             o_compare_b_irq,
  output logic             o_wrap_irq,
  output logic             o_irq,
  output logic [1:0]       o_irq_top_code,
  output logic             o_filter_out
);

  logic          pin_meta_reg;
  logic          pin_sync_reg;
  logic          ext_meta_reg;
  logic          ext_sync_reg;
  logic [3:0]    ctrl_reg;
  logic [1:0]    sample_sel_reg;
  frt_flags_type flags_reg;
  frt_flags_type irq_en_reg;
  frt_flags_type flags_set;
  frt_flags_type flags_clr;
  logic [15:0]   counter_reg;
  logic [15:0]   compare_value_a;
  logic [15:0]   compare_value_b;
  logic [15:0]   captured_value;
  logic [6:0]    presc_reg;
  logic          src_prev_reg;
  logic          src_lvl;
  logic          inc;
  logic [3:0]    latch_reg;
  logic          filt_out_reg;
  logic          smp_strobe;
  logic          cap_src;
  logic          cap_prev_reg;
  logic          cap_edge;
  logic          cap_pend_reg;
  logic          cap_strobe;
  logic          cap_read;
  logic          eq_a_prev_reg;
  logic          eq_b_prev_reg;
  logic          eq_a;
  logic          eq_b;
  logic          match_a;
  logic          match_b;
  logic          cnt_clear;
  logic          wr_lo;
  logic          hit_cnt;
  logic          hit_cmpa;
  logic          hit_cmpb;
  logic [15:0]   cnt_wr_val;
  logic          rd_ack_reg;
  logic [31:0]   readdata_reg;
  logic [31:0]   rd_mux;

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be);
    logic [15:0] r;
    r = old_v;
    if (be[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (be[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction : merge16

  // pin and external clock both cross in through two flops
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
    end else begin
      pin_meta_reg <= i_capture_pin;
      pin_sync_reg <= pin_meta_reg;
      ext_meta_reg <= i_ext_clk;
      ext_sync_reg <= ext_meta_reg;
    end
  end

  // bus decode; a low lane write stands for the third bus state
  assign wr_lo    = i_avs_write & i_avs_byteenable[0];
  assign hit_cnt  = i_avs_address == OFS_COUNTER;
  assign hit_cmpa = i_avs_address == OFS_CMP_A;
  assign hit_cmpb = i_avs_address == OFS_CMP_B;
  assign cap_read = i_avs_read & (i_avs_address == OFS_CAPTURED)
                  & i_avs_byteenable[1];
  assign cnt_wr_val = merge16(counter_reg, i_avs_writedata,
                              i_avs_byteenable);

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      ctrl_reg       <= CTRL_RST;
      sample_sel_reg <= FILTER_RST[1:0];
      irq_en_reg     <= '0;
    end else if (i_avs_write & i_avs_byteenable[0]) begin
      if (i_avs_address == OFS_CONTROL) begin
        ctrl_reg <= i_avs_writedata[3:0];
      end
      if (i_avs_address == OFS_FILTER) begin
        sample_sel_reg <= i_avs_writedata[1:0];
      end
      if (i_avs_address == OFS_IRQ_EN) begin
        irq_en_reg <= i_avs_writedata[3:0];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      compare_value_a <= COMPARE_RST;
      compare_value_b <= COMPARE_RST;
    end else if (i_avs_write) begin
      if (hit_cmpa) begin
        compare_value_a <= merge16(compare_value_a, i_avs_writedata,
                                   i_avs_byteenable);
      end
      if (hit_cmpb) begin
        compare_value_b <= merge16(compare_value_b, i_avs_writedata,
                                   i_avs_byteenable);
      end
    end
  end

  // reads answer one cycle late so the data come from a flop
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (i_avs_address)
      OFS_CONTROL:  rd_mux[3:0]  = ctrl_reg;
      OFS_STATUS:   rd_mux[3:0]  = flags_reg;
      OFS_IRQ_EN:   rd_mux[3:0]  = irq_en_reg;
      OFS_COUNTER:  rd_mux[15:0] = counter_reg;
      OFS_CMP_A:    rd_mux[15:0] = compare_value_a;
      OFS_CMP_B:    rd_mux[15:0] = compare_value_b;
      OFS_CAPTURED: rd_mux[15:0] = captured_value;
      OFS_FILTER:   rd_mux[7:0]  = {FILTER_RST[7:2], sample_sel_reg};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      rd_ack_reg   <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else begin
      rd_ack_reg <= i_avs_read & ~rd_ack_reg;
      if (i_avs_read & ~rd_ack_reg) begin
        readdata_reg <= rd_mux;
      end
    end
  end

  assign o_avs_waitrequest = i_avs_read & ~rd_ack_reg;
  assign o_avs_readdata    = readdata_reg;

  // one prescaler serves both the internal count sources and sample clocks
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      presc_reg    <= 7'h00;
      src_prev_reg <= 1'b0;
    end else begin
      presc_reg    <= presc_reg + 7'h01;
      src_prev_reg <= src_lvl;
    end
  end

  // external clock inverted so its rising edge is a falling one
  always_comb begin
    unique case (ctrl_reg[CTL_CLK_HI:CTL_CLK_LO])
      CLK_DIV2:  src_lvl = presc_reg[TAP_DIV2];
      CLK_DIV8:  src_lvl = presc_reg[TAP_DIV8];
      CLK_DIV32: src_lvl = presc_reg[TAP_DIV32];
      CLK_EXT:   src_lvl = ~ext_sync_reg;
    endcase
  end

  // previous level of whatever was selected: a switch from a high
  // source to a low one looks like a falling edge
  assign inc = src_prev_reg & ~src_lvl; // [RL11] [RL12] [RL13]

  always_comb begin
    unique case (sample_sel_reg) // [RL7]
      SMP_OFF: smp_strobe = 1'b0;
      SMP_32:  smp_strobe = (presc_reg & MASK_32) == MASK_32;
      SMP_64:  smp_strobe = (presc_reg & MASK_64) == MASK_64;
      SMP_128: smp_strobe = presc_reg == MASK_128;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      latch_reg    <= 4'h0;
      filt_out_reg <= 1'b0; // [RL6]
    end else begin
      if (smp_strobe) begin
        latch_reg <= {latch_reg[2:0], pin_sync_reg}; // [RL4]
      end
      if (&latch_reg) begin
        filt_out_reg <= 1'b1; // [RL5]
      end else if (~|latch_reg) begin
        filt_out_reg <= 1'b0; // [RL5]
      end
    end
  end

  assign o_filter_out = filt_out_reg;
  assign cap_src  = (sample_sel_reg == SMP_OFF) ? pin_sync_reg
                                                : filt_out_reg;
  assign cap_edge = ctrl_reg[CTL_EDGE] ? (cap_src & ~cap_prev_reg)
                                       : (~cap_src & cap_prev_reg);
  // a read of the captured value holds the capture off one cycle
  assign cap_strobe = cap_pend_reg | (cap_edge & ~cap_read); // [RL14]

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      cap_prev_reg   <= 1'b0;
      cap_pend_reg   <= 1'b0;
      captured_value <= COUNTER_RST;
    end else begin
      cap_prev_reg <= cap_src;
      cap_pend_reg <= cap_edge & cap_read; // [RL14]
      if (cap_strobe) begin
        captured_value <= counter_reg; // [RL15]
      end
    end
  end

  // match fires on arrival at the compare value, not while it sits
  assign eq_a    = counter_reg == compare_value_a;
  assign eq_b    = counter_reg == compare_value_b;
  assign match_a = eq_a & ~eq_a_prev_reg & ~(wr_lo & hit_cmpa); // [RL10]
  assign match_b = eq_b & ~eq_b_prev_reg & ~(wr_lo & hit_cmpb); // [RL10]
  assign cnt_clear = match_a & ctrl_reg[CTL_CLRA];

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      eq_a_prev_reg <= 1'b0;
      eq_b_prev_reg <= 1'b0;
      counter_reg   <= COUNTER_RST;
    end else begin
      eq_a_prev_reg <= eq_a;
      eq_b_prev_reg <= eq_b;
      if (cnt_clear) begin
        counter_reg <= COUNTER_RST; // [RL8]
      end else if (i_avs_write & hit_cnt) begin
        counter_reg <= cnt_wr_val; // [RL9]
      end else if (inc) begin
        counter_reg <= counter_reg + 16'h0001;
      end
    end
  end

  always_comb begin
    flags_set.capture = cap_strobe; // [RL15]
    flags_set.match_a = match_a;
    flags_set.match_b = match_b;
    flags_set.wrap    = inc & ~cnt_clear & ~(i_avs_write & hit_cnt)
                      & (counter_reg == COUNT_MAX); // [RL16]
    flags_clr = '0;
    if (i_avs_write & i_avs_byteenable[0]
        & (i_avs_address == OFS_STATUS)) begin
      flags_clr = i_avs_writedata[3:0];
    end
  end

  // an event in the cycle of its write-one clear is kept
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= (flags_reg & ~flags_clr) | flags_set;
    end
  end

  // levels straight from flag and enable flops [RL17]
  assign o_capture_irq   = flags_reg.capture & irq_en_reg.capture; // [RL1]
  assign o_compare_a_irq = flags_reg.match_a & irq_en_reg.match_a; // [RL2]
  assign o_compare_b_irq = flags_reg.match_b & irq_en_reg.match_b; // [RL2]
  assign o_wrap_irq      = flags_reg.wrap & irq_en_reg.wrap; // [RL1]
  assign o_irq = o_capture_irq | o_compare_a_irq | o_compare_b_irq
               | o_wrap_irq;

  always_comb begin
    if (o_capture_irq) begin
      o_irq_top_code = CODE_CAP; // [RL3]
    end else if (o_compare_a_irq) begin
      o_irq_top_code = CODE_MA;
    end else if (o_compare_b_irq) begin
      o_irq_top_code = CODE_MB;
    end else begin
      o_irq_top_code = CODE_WRAP;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  property p_irq_rise;
    $rose(flags_reg.capture) && irq_en_reg.capture |-> o_capture_irq;
  endproperty
  a_irq_rise: assert property (p_irq_rise) // [RL1]
    else $error("capture request missing");

  property p_irq_drop;
    o_wrap_irq && flags_clr.wrap && !flags_set.wrap |=> !o_wrap_irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) // [RL17]
    else $error("wrap request did not drop");

  property p_top_code;
    o_compare_a_irq && !o_capture_irq |-> o_irq_top_code == CODE_MA;
  endproperty
  a_top_code: assert property (p_top_code) // [RL3]
    else $error("wrong priority code");

  property p_filter_hold;
    (latch_reg != 4'h0) && (latch_reg != 4'hF) |=> $stable(filt_out_reg);
  endproperty
  a_filter_hold: assert property (p_filter_hold) // [RL5]
    else $error("filter moved on disagreement");

  property p_filter_reset;
    disable iff (1'b0) !i_resetn |=> !filt_out_reg;
  endproperty
  a_filter_reset: assert property (p_filter_reset) // [RL6]
    else $error("filter not low after reset");

  property p_clear_wins;
    cnt_clear && i_avs_write && hit_cnt |=> counter_reg == COUNTER_RST;
  endproperty
  a_clear_wins: assert property (p_clear_wins) // [RL8]
    else $error("write beat clear");

  property p_write_wins;
    inc && !cnt_clear && i_avs_write && hit_cnt
      |=> counter_reg == $past(cnt_wr_val);
  endproperty
  a_write_wins: assert property (p_write_wins) // [RL9]
    else $error("increment beat write");

  property p_match_inhibit;
    wr_lo && hit_cmpa |=> !flags_reg.match_a || $past(flags_reg.match_a);
  endproperty
  a_match_inhibit: assert property (p_match_inhibit) // [RL10]
    else $error("match set during compare write");

  property p_capture_copy;
    cap_strobe |=> captured_value == $past(counter_reg)
                   && flags_reg.capture;
  endproperty
  a_capture_copy: assert property (p_capture_copy) // [RL15]
    else $error("capture copy or flag wrong");

  property p_wrap_flag;
    counter_reg == COUNT_MAX ##1 counter_reg == COUNTER_RST
      && !$past(cnt_clear) && !$past(i_avs_write) |-> flags_reg.wrap;
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) // [RL16]
    else $error("wrap flag not set");

  property p_count_edge;
    inc && !cnt_clear && !(i_avs_write && hit_cnt)
      |=> counter_reg == $past(counter_reg) + 16'h0001;
  endproperty
  a_count_edge: assert property (p_count_edge) // [RL11]
    else $error("falling edge did not count");

  property p_sample_off;
    sample_sel_reg == SMP_OFF |=> $stable(latch_reg);
  endproperty
  a_sample_off: assert property (p_sample_off) // [RL7]
    else $error("sampling while filter off");

endmodule : frt_timer_irq_filter
`default_nettype wire

// ==== dv/frt_irq_ctrl_model.sv ====
// interrupt controller model: ranks the four request lines
`timescale 1ns/1ps
`default_nettype none
module frt_irq_ctrl_model
  import frt_pkg::*;
(
  input  wire logic       i_capture_irq,
  input  wire logic       i_compare_a_irq,
  input  wire logic       i_compare_b_irq,
  input  wire logic       i_wrap_irq,
  output logic            o_any,
  output logic [1:0]      o_top_code
);
  // each line is watched on its own, never a shared request
  always_comb begin
    o_any = i_capture_irq | i_compare_a_irq | i_compare_b_irq | i_wrap_irq;
    if (i_capture_irq) o_top_code = CODE_CAP;
    else if (i_compare_a_irq) o_top_code = CODE_MA;
    else if (i_compare_b_irq) o_top_code = CODE_MB;
    else o_top_code = CODE_WRAP;
  end
endmodule : frt_irq_ctrl_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for the timer interrupt and capture filter block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import frt_pkg::*;
  logic        clk_sys;
  logic        resetn;
  logic        capture_pin;
  logic        ext_clk;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  lines;
  logic        irq;
  logic [1:0]  top_code;
  logic        filter_out;
  logic        m_any;
  logic [1:0]  m_top;
  logic [15:0] rnd;
  int          miscompares;
  int          compares;
  int          n;

  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;

  frt_timer_irq_filter frt_timer_irq_filter_i (
    .i_clk_sys(clk_sys), .i_resetn(resetn), .i_capture_pin(capture_pin),
    .i_ext_clk(ext_clk), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
    .o_capture_irq(lines[0]), .o_compare_a_irq(lines[1]),
    .o_compare_b_irq(lines[2]), .o_wrap_irq(lines[3]), .o_irq(irq),
    .o_irq_top_code(top_code), .o_filter_out(filter_out));

  frt_irq_ctrl_model frt_irq_ctrl_model_i (
    .i_capture_irq(lines[0]), .i_compare_a_irq(lines[1]),
    .i_compare_b_irq(lines[2]), .i_wrap_irq(lines[3]),
    .o_any(m_any), .o_top_code(m_top));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // request stands until the rising edge that sees waitrequest low;
  // read data are taken at that same edge, then the request drops
  task automatic bus(input logic wr, input logic [4:0] addr,
                     input logic [31:0] data, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk_sys);
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_address   <= addr;
    avs_writedata <= data;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      check("waitrequest", 32'h0, {31'h0, avs_waitrequest});
    end
  endtask : bus

  task automatic wr(input logic [4:0] addr, input logic [31:0] data);
    logic [31:0] q;
    bus(1'b1, addr, data, q);
  endtask : wr

  task automatic rd_chk(input logic [4:0] addr, input logic [31:0] exp,
                        input string what);
    logic [31:0] q;
    bus(1'b0, addr, 32'h0, q);
    check(what, exp, q);
  endtask : rd_chk

  // one count of the external source; it is synced, so hold it wide
  task automatic ext_pulse;
    @(posedge clk_sys) ext_clk <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ext_clk <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask : ext_pulse

  // request lines, expected rank and the controller model's view
  task automatic irq_chk(input logic [3:0] exp, input logic [1:0] top);
    @(negedge clk_sys);
    check("irq lines", {28'h0, exp}, {28'h0, lines});
    check("irq any", {31'h0, |exp}, {31'h0, irq});
    check("top code", {30'h0, top}, {30'h0, top_code});
    check("model top", {30'h0, top}, {30'h0, m_top});
    check("model any", {31'h0, |exp}, {31'h0, m_any});
  endtask : irq_chk

  // cycles until the filter output reaches lvl
  task automatic settle(input logic lvl, input int lim, output int c);
    c = 0;
    do begin
      @(negedge clk_sys);
      c++;
    end while (filter_out !== lvl && c < lim);
  endtask : settle

  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  initial begin
    repeat (80000) @(posedge clk_sys);
    miscompares++;
    final_report();
  end

  initial begin
    int c;
    int held;
    miscompares = 0;
    compares = 0;
    rnd = 16'h0046;
    resetn = 1'b0;
    capture_pin = 1'b0;
    ext_clk = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    check("filter_out", 32'h0, {31'h0, filter_out});
    rd_chk(OFS_FILTER, 32'h0000_00FC, "filter ctl");
    rd_chk(OFS_STATUS, 32'h0000_0000, "status");
    irq_chk(4'h0, CODE_WRAP);
    // external source held low freezes the counter; rising edge capture
    wr(OFS_CONTROL, 32'h0000_0007);
    wr(OFS_CMP_B, 32'h0000_1234);
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr_next(rnd);
      wr(OFS_COUNTER, {16'h0, rnd});
      rd_chk(OFS_COUNTER, {16'h0, rnd}, "counter");
      ext_pulse();
      rd_chk(OFS_COUNTER, {16'h0, rnd + 16'h0001}, "count");
    end
    wr(OFS_STATUS, 32'h0000_000F);
    wr(OFS_IRQ_EN, 32'h0000_000F);
    wr(OFS_CMP_A, 32'h0000_0000);
    wr(OFS_COUNTER, 32'h0000_FFFF);
    ext_pulse();
    rd_chk(OFS_STATUS, 32'h0000_000A, "wrap and match");
    irq_chk(4'hA, CODE_MA);
    wr(OFS_COUNTER, 32'h0000_5A5A);
    @(posedge clk_sys) capture_pin <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rd_chk(OFS_CAPTURED, 32'h0000_5A5A, "captured");
    rd_chk(OFS_STATUS, 32'h0000_000B, "capture flag");
    irq_chk(4'hB, CODE_CAP);
    wr(OFS_IRQ_EN, 32'h0000_000E);
    irq_chk(4'hA, CODE_MA);
    wr(OFS_STATUS, 32'h0000_0002);
    irq_chk(4'h8, CODE_WRAP);
    wr(OFS_IRQ_EN, 32'h0000_0000);
    irq_chk(4'h0, CODE_WRAP);
    // clear on match a: counter holds the match value one cycle, then zero
    wr(OFS_CONTROL, 32'h0000_000F);
    wr(OFS_CMP_A, 32'h0000_0010);
    wr(OFS_COUNTER, 32'h0000_000F);
    ext_pulse();
    rd_chk(OFS_COUNTER, 32'h0000_0000, "cleared");
    // counter write lands in the cycle of the clear: the clear is kept
    wr(OFS_COUNTER, 32'h0000_000F);
    @(posedge clk_sys) ext_clk <= 1'b1;
    repeat (2) @(posedge clk_sys);
    wr(OFS_COUNTER, 32'h0000_0077);
    ext_clk <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd_chk(OFS_COUNTER, 32'h0000_0000, "clear vs write");
    wr(OFS_CONTROL, 32'h0000_0007);
    // counter write lands in the cycle of an increment: no count
    @(posedge clk_sys) ext_clk <= 1'b1;
    @(posedge clk_sys);
    wr(OFS_COUNTER, 32'h0000_0123);
    ext_clk <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd_chk(OFS_COUNTER, 32'h0000_0123, "write vs count");
    // compare write lands in the cycle of its match: no flag
    wr(OFS_CMP_A, 32'h0000_0124);
    wr(OFS_STATUS, 32'h0000_000F);
    @(posedge clk_sys) ext_clk <= 1'b1;
    repeat (2) @(posedge clk_sys);
    wr(OFS_CMP_A, 32'h0000_0200);
    ext_clk <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd_chk(OFS_STATUS, 32'h0000_0000, "match vs write");
    // each sample rate: reject a short glitch, pass a wide level
    for (int s = 1; s < 4; s++) begin
      n = 32 << (s - 1);
      wr(OFS_FILTER, s);
      settle(1'b1, 6 * n + 16, c);
      check("filter high", 32'h1, {31'h0, filter_out});
      @(posedge clk_sys) capture_pin <= 1'b0;
      repeat (2 * n) @(posedge clk_sys);
      capture_pin <= 1'b1;
      held = 1;
      for (int k = 0; k < 6 * n; k++) begin
        @(negedge clk_sys);
        if (filter_out !== 1'b1) held = 0;
      end
      check("glitch held", 32'h1, held);
      @(posedge clk_sys) capture_pin <= 1'b0;
      settle(1'b0, 6 * n + 16, c);
      check("fall low", 32'h0, {31'h0, filter_out});
      check("fall delay", 32'h1, (c >= 3 * n && c <= 5 * n + 8));
      @(posedge clk_sys) capture_pin <= 1'b1;
      settle(1'b1, 6 * n + 16, c);
      check("rise delay", 32'h1, (c >= 3 * n && c <= 5 * n + 8));
    end
    final_report();
  end
endmodule : tb_top
`default_nettype wire
